// ### src/sense_trim_pkg.sv
`default_nettype none

package sense_trim_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SECOND_VALUE = 8'h16;
  localparam logic [7:0] IDX_LOAD_VALUE = 8'h17;
  localparam logic [7:0] IDX_SECOND_TRIM = 8'h39;
  localparam logic [7:0] IDX_LOAD_TRIM = 8'h3a;
  localparam logic [7:0] IDX_LIGHT_LOAD_MASK = 8'h3b;
  localparam logic [7:0] IDX_LIGHT_LOAD_STATUS = 8'h3c;

  // trim register fields
  localparam int TRIM_SIGN_BIT = 7;
  localparam int TRIM_MAG_MSB = 6;
  localparam int TRIM_MAG_W = 7;

  // light-load register fields
  localparam int MASK_AUX_BIT = 7;
  localparam int MASK_D_BIT = 6;
  localparam int MASK_C_BIT = 5;
  localparam int MASK_B_BIT = 4;
  localparam int MASK_A_BIT = 3;
  localparam int THRESH_MSB = 2;
  localparam int THRESH_W = 3;

  // reset values
  localparam logic [7:0] SECOND_TRIM_RESET = 8'h00;
  localparam logic [7:0] LOAD_TRIM_RESET = 8'h00;
  localparam logic [7:0] LIGHT_LOAD_MASK_RESET = 8'h00;

  // light-load hysteresis, in millivolts across the sense pins
  localparam int HYST_MV = 8;

  // calibration target that software trims towards at 1 V input
  localparam logic [11:0] CAL_TARGET_CODE = 12'ha53;

  // AHB-Lite transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;

endpackage : sense_trim_pkg

`default_nettype wire

// ### src/gain_trim_scale.sv
`timescale 1ns/100ps
`default_nettype none

module gain_trim_scale #(
  parameter int DATA_W = 12,
  parameter int MAG_W = 7,
  parameter int SHIFT = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [DATA_W-1:0] raw,
  input wire logic negative,
  input wire logic [MAG_W-1:0] magnitude,
  output logic [DATA_W-1:0] scaled
);

  localparam int PROD_W = DATA_W + MAG_W;

  generate
    if (SHIFT < MAG_W || DATA_W < 2)
    begin : g_bad_params
      $error("gain_trim_scale: SHIFT must cover the magnitude width");
    end
  endgenerate

  typedef struct packed {
    logic [DATA_W-1:0] scaled;
  } state_t;

  state_t r;
  state_t next_r;
  logic [PROD_W-1:0] delta;
  logic [PROD_W:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    delta = (PROD_W'(raw) * PROD_W'(magnitude)) >> SHIFT;
    // correction is a fraction of the reading; the sign bit picks direction
    if (negative)
    begin
      sum = {1'b0, PROD_W'(raw)} - {1'b0, delta};
      // clamp at zero instead of wrapping on a large negative trim
      next_r.scaled = sum[PROD_W] ? '0 : sum[DATA_W-1:0];
    end
    else
    begin
      sum = {1'b0, PROD_W'(raw)} + {1'b0, delta};
      next_r.scaled = (sum[PROD_W:DATA_W] != '0) ? '1 : sum[DATA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign scaled = r.scaled;

endmodule : gain_trim_scale

`default_nettype wire

// ### src/sense_trim_light_load_ctrl.sv
// Behaviour
// RULE_01: trim bit 7 set means negative correction
// RULE_02: second channel magnitude scales its ADC reading
// RULE_03: software trims second channel toward 2643 at 1V
// RULE_04: load channel magnitude scales its ADC reading
// RULE_05: software trims load channel toward 2643 at 1V
// RULE_06: software trims load gain before OV/UV trims
// RULE_07: mask bit 7 drops auxiliary output at light load
// RULE_08: mask bit 6 drops output D at light load
// RULE_09: mask bit 5 drops output C at light load
// RULE_10: mask bit 4 drops output B at light load
// RULE_11: mask bit 3 drops output A at light load
// RULE_12: hysteretic light-load compare gates rectifiers, selects filter; no filter here, the state is brought out on light_load_mode instead
// RULE_13: unmasked outputs switch normally; fields read back exactly
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module sense_trim_light_load_ctrl #(
  parameter int ADC_W = 12,
  parameter int CS_W = 12,
  parameter int TRIM_SHIFT = 10,
  parameter int COUNTS_PER_MV = 4,
  parameter int THRESH_STEP_COUNTS = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // raw readings from the converters
  input wire logic [ADC_W-1:0] second_voltage_sense_raw,
  input wire logic [ADC_W-1:0] load_voltage_sense_raw,
  input wire logic [CS_W-1:0] load_current_sense,
  // corrected readings
  output logic [ADC_W-1:0] second_voltage_sense_value,
  output logic [ADC_W-1:0] load_voltage_sense_value,
  // drive from the modulator
  input wire logic pwm_channel_a_in,
  input wire logic pwm_channel_b_in,
  input wire logic pwm_channel_c_in,
  input wire logic pwm_channel_d_in,
  input wire logic auxiliary_pwm_output_in,
  input wire logic sync_rectifier_drive_1_in,
  input wire logic sync_rectifier_drive_2_in,
  // gated drive
  output logic pwm_channel_a,
  output logic pwm_channel_b,
  output logic pwm_channel_c,
  output logic pwm_channel_d,
  output logic auxiliary_pwm_output,
  output logic sync_rectifier_drive_1,
  output logic sync_rectifier_drive_2,
  output logic light_load_mode
);

  localparam int CMP_W = CS_W + 2;
  localparam int HYST_COUNTS = sense_trim_pkg::HYST_MV * COUNTS_PER_MV;

  generate
    if (ADC_W > 32 || CS_W > 30 || ADC_W < 12 || COUNTS_PER_MV < 1)
    begin : g_bad_params
      $error("sense_trim_light_load_ctrl: unsupported widths or scale");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] second_trim;
    logic [7:0] load_trim;
    logic [7:0] mask;
    logic light_load;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic out_a;
    logic out_b;
    logic out_c;
    logic out_d;
    logic out_aux;
    logic out_sr1;
    logic out_sr2;
  } state_t;

  state_t r;
  state_t next_r;
  logic addr_take;
  logic [7:0] idx;
  logic in_map;
  logic [CMP_W-1:0] thresh;
  logic [CMP_W-1:0] cs_ext;
  logic ll;

  ////////////////////////////////////////////////////////////////////////////
  // word index from the byte address; whether the upper address bits leave it in the map is checked separately
  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = a[9:2];
  endfunction : word_index

  function automatic logic gate(input logic drive, input logic mask_bit,
                                input logic light);
    gate = drive & ~(mask_bit & light);
  endfunction : gate

  ////////////////////////////////////////////////////////////////////////////
  gain_trim_scale #(
    .DATA_W(ADC_W),
    .MAG_W(sense_trim_pkg::TRIM_MAG_W),
    .SHIFT(TRIM_SHIFT)
  ) u_second_scale (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(second_voltage_sense_raw),
    .negative(r.second_trim[sense_trim_pkg::TRIM_SIGN_BIT]), // see RULE_01
    .magnitude(r.second_trim[sense_trim_pkg::TRIM_MAG_MSB:0]), // see RULE_02
    .scaled(second_voltage_sense_value)
  );

  gain_trim_scale #(
    .DATA_W(ADC_W),
    .MAG_W(sense_trim_pkg::TRIM_MAG_W),
    .SHIFT(TRIM_SHIFT)
  ) u_load_scale (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(load_voltage_sense_raw),
    .negative(r.load_trim[sense_trim_pkg::TRIM_SIGN_BIT]), // see RULE_01
    .magnitude(r.load_trim[sense_trim_pkg::TRIM_MAG_MSB:0]), // see RULE_04
    .scaled(load_voltage_sense_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    addr_take = hsel && hready && (htrans == sense_trim_pkg::HTRANS_NONSEQ ||
                                   htrans == sense_trim_pkg::HTRANS_SEQ);
    idx = word_index(haddr);
    in_map = (haddr[31:10] == '0);

    // data phase of a write; the low eight bits land so field readback is exact
    if (r.wr_pend)
    begin
      unique case (r.wr_idx)
        sense_trim_pkg::IDX_SECOND_TRIM: next_r.second_trim = hwdata[7:0];
        sense_trim_pkg::IDX_LOAD_TRIM: next_r.load_trim = hwdata[7:0];
        sense_trim_pkg::IDX_LIGHT_LOAD_MASK: next_r.mask = hwdata[7:0];
        default: ; // read-only or unmapped: write ignored
      endcase // see RULE_13
    end
    next_r.wr_pend = addr_take && hwrite && in_map;
    next_r.wr_idx = idx;

    // read data is taken from the updated copy, so a read right behind a
    // write to the same word sees the new value
    if (addr_take && !hwrite)
    begin
      next_r.rdata = '0;
      if (in_map)
      begin
        unique case (idx)
          sense_trim_pkg::IDX_SECOND_VALUE:
            next_r.rdata[ADC_W-1:0] = second_voltage_sense_value;
          sense_trim_pkg::IDX_LOAD_VALUE:
            next_r.rdata[ADC_W-1:0] = load_voltage_sense_value;
          sense_trim_pkg::IDX_SECOND_TRIM:
            next_r.rdata[7:0] = next_r.second_trim; // see RULE_13
          sense_trim_pkg::IDX_LOAD_TRIM:
            next_r.rdata[7:0] = next_r.load_trim; // see RULE_13
          sense_trim_pkg::IDX_LIGHT_LOAD_MASK:
            next_r.rdata[7:0] = next_r.mask; // see RULE_13
          sense_trim_pkg::IDX_LIGHT_LOAD_STATUS:
            next_r.rdata[0] = r.light_load;
          default: ;
        endcase
      end
    end

    // threshold from the low mask field, hysteresis above it
    thresh = CMP_W'(r.mask[sense_trim_pkg::THRESH_MSB:0]) *
             CMP_W'(THRESH_STEP_COUNTS);
    cs_ext = CMP_W'(load_current_sense);
    ll = r.light_load;
    if (!r.light_load && cs_ext < thresh)
      ll = 1'b1; // see RULE_12
    else if (r.light_load && cs_ext >= thresh + CMP_W'(HYST_COUNTS))
      ll = 1'b0; // see RULE_12
    next_r.light_load = ll;

    // an output with its mask bit clear passes regardless of load
    next_r.out_aux = gate(auxiliary_pwm_output_in,
                          r.mask[sense_trim_pkg::MASK_AUX_BIT],
                          r.light_load); // see RULE_07
    next_r.out_d = gate(pwm_channel_d_in, r.mask[sense_trim_pkg::MASK_D_BIT],
                        r.light_load); // see RULE_08
    next_r.out_c = gate(pwm_channel_c_in, r.mask[sense_trim_pkg::MASK_C_BIT],
                        r.light_load); // see RULE_09
    next_r.out_b = gate(pwm_channel_b_in, r.mask[sense_trim_pkg::MASK_B_BIT],
                        r.light_load); // see RULE_10
    next_r.out_a = gate(pwm_channel_a_in, r.mask[sense_trim_pkg::MASK_A_BIT],
                        r.light_load); // see RULE_11, see RULE_13
    // rectifiers always drop at light load, no mask involved
    next_r.out_sr1 = gate(sync_rectifier_drive_1_in, 1'b1,
                          r.light_load); // see RULE_12
    next_r.out_sr2 = gate(sync_rectifier_drive_2_in, 1'b1,
                          r.light_load); // see RULE_12
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.second_trim <= sense_trim_pkg::SECOND_TRIM_RESET;
      r.load_trim <= sense_trim_pkg::LOAD_TRIM_RESET;
      r.mask <= sense_trim_pkg::LIGHT_LOAD_MASK_RESET;
    end
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign pwm_channel_a = r.out_a;
  assign pwm_channel_b = r.out_b;
  assign pwm_channel_c = r.out_c;
  assign pwm_channel_d = r.out_d;
  assign auxiliary_pwm_output = r.out_aux;
  assign sync_rectifier_drive_1 = r.out_sr1;
  assign sync_rectifier_drive_2 = r.out_sr2;
  assign light_load_mode = r.light_load;

endmodule : sense_trim_light_load_ctrl

`default_nettype wire

// ### dv/sense_trim_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module sense_trim_assertions #(
  parameter int CS_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [CS_W-1:0] load_current_sense,
  input wire logic light_load_mode,
  input wire logic pwm_channel_a_in,
  input wire logic pwm_channel_b_in,
  input wire logic pwm_channel_c_in,
  input wire logic pwm_channel_d_in,
  input wire logic auxiliary_pwm_output_in,
  input wire logic sync_rectifier_drive_1_in,
  input wire logic sync_rectifier_drive_2_in,
  input wire logic pwm_channel_a,
  input wire logic pwm_channel_b,
  input wire logic pwm_channel_c,
  input wire logic pwm_channel_d,
  input wire logic auxiliary_pwm_output,
  input wire logic sync_rectifier_drive_1,
  input wire logic sync_rectifier_drive_2
);
  // highest threshold code plus hysteresis, so no code can hold light load
  localparam int LEAVE_ALL = 74;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  a_pass_out_a: assert property (
    !light_load_mode |=> pwm_channel_a == $past(pwm_channel_a_in))
    else $error("output a not passed");
  a_pass_out_b: assert property (
    !light_load_mode |=> pwm_channel_b == $past(pwm_channel_b_in))
    else $error("output b not passed");
  a_pass_out_c: assert property (
    !light_load_mode |=> pwm_channel_c == $past(pwm_channel_c_in))
    else $error("output c not passed");
  a_pass_out_d: assert property (
    !light_load_mode |=> pwm_channel_d == $past(pwm_channel_d_in))
    else $error("output d not passed");
  a_pass_aux: assert property (
    !light_load_mode ##1 1'b1 |->
      auxiliary_pwm_output == $past(auxiliary_pwm_output_in))
    else $error("aux output not passed");
  a_gate_rect_one: assert property (
    1'b1 |=> sync_rectifier_drive_1 ==
      ($past(sync_rectifier_drive_1_in) && !$past(light_load_mode)))
    else $error("rectifier 1 gating wrong");
  a_gate_rect_two: assert property (
    1'b1 |=> sync_rectifier_drive_2 ==
      ($past(sync_rectifier_drive_2_in) && !$past(light_load_mode)))
    else $error("rectifier 2 gating wrong");
  a_heavy_load_exit: assert property (
    load_current_sense >= LEAVE_ALL |=> !light_load_mode)
    else $error("light load held at heavy load");
endmodule : sense_trim_assertions

bind sense_trim_light_load_ctrl sense_trim_assertions #(.CS_W(CS_W)) chk_i (
  .ref_clk, .rst_n, .load_current_sense, .light_load_mode,
  .pwm_channel_a_in, .pwm_channel_b_in, .pwm_channel_c_in, .pwm_channel_d_in,
  .auxiliary_pwm_output_in, .sync_rectifier_drive_1_in,
  .sync_rectifier_drive_2_in, .pwm_channel_a, .pwm_channel_b,
  .pwm_channel_c, .pwm_channel_d, .auxiliary_pwm_output,
  .sync_rectifier_drive_1, .sync_rectifier_drive_2);

`default_nettype wire

// ### dv/sense_trim_light_load_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module sense_trim_light_load_ctrl_tb;
  localparam logic [7:0] RW_IDX [3] = '{sense_trim_pkg::IDX_SECOND_TRIM,
    sense_trim_pkg::IDX_LOAD_TRIM, sense_trim_pkg::IDX_LIGHT_LOAD_MASK};
  // raw 0x400 and 0x800 at full magnitude, positive then negative
  localparam logic [31:0] EXP [4] = '{32'h47f, 32'h8fe, 32'h381, 32'h702};
  localparam logic [11:0] CS_SEQ [4] = '{12'h025, 12'h026, 12'h006, 12'h005};
  localparam logic [7:0] OUT_SEQ [4] = '{8'h8f, 8'h7f, 8'h7f, 8'h8f};

  logic ref_clk, rst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] raw2, raw3, cs;
  logic [6:0] drv;
  wire logic hready, hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [7:0] outs;
  wire logic [11:0] val2, val3;
  int errors, checked;

  assign hready = hreadyout;

  sense_trim_light_load_ctrl DUT (
    .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata,
    .second_voltage_sense_raw(raw2), .load_voltage_sense_raw(raw3),
    .load_current_sense(cs),
    .second_voltage_sense_value(val2), .load_voltage_sense_value(val3),
    .pwm_channel_a_in(drv[0]), .pwm_channel_b_in(drv[1]),
    .pwm_channel_c_in(drv[2]), .pwm_channel_d_in(drv[3]),
    .auxiliary_pwm_output_in(drv[4]), .sync_rectifier_drive_1_in(drv[5]),
    .sync_rectifier_drive_2_in(drv[6]),
    .pwm_channel_a(outs[0]), .pwm_channel_b(outs[1]),
    .pwm_channel_c(outs[2]), .pwm_channel_d(outs[3]),
    .auxiliary_pwm_output(outs[4]), .sync_rectifier_drive_1(outs[5]),
    .sync_rectifier_drive_2(outs[6]), .light_load_mode(outs[7]));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for a ready edge; a stuck bus ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      errors++;
      report_and_stop();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] got);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= sense_trim_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    got = hrdata;
    checked++;
    if (hresp !== 1'b0 || hreadyout !== 1'b1)
    begin
      errors++;
      $display("MISMATCH t=%0t bus response not OKAY", $time);
    end
  endtask : bus

  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] unused;
    bus(1'b1, idx, wd, unused);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, idx, 32'h00000000, got);
    chk(got, exp);
  endtask : rd_reg

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] m;
    errors = 0;
    checked = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = 3'h2;
    raw2 = 12'h400;
    raw3 = 12'h800;
    cs = 12'h000;
    drv = 7'h00;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 3; i++)
      rd_reg(RW_IDX[i], 32'h00000000);
    // upper bits written as ones must not stick
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(RW_IDX[i], {24'hffffff, 8'h5a + 8'(i)});
      rd_reg(RW_IDX[i], {24'h000000, 8'h5a + 8'(i)});
    end
    rd_reg(8'h01, 32'h00000000);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(RW_IDX[i % 2], {24'h000000, (i < 2) ? 8'h7f : 8'hff});
      repeat (2) @(posedge ref_clk);
      rd_reg(sense_trim_pkg::IDX_SECOND_VALUE + 8'(i % 2), EXP[i]);
    end
    drv <= 7'h7f;
    for (int b = 2; b < 8; b++)
    begin
      m = (b > 2) ? 8'(1 << b) : 8'h00;
      wr_reg(sense_trim_pkg::IDX_LIGHT_LOAD_MASK, {24'h000000, m | 8'h01});
      repeat (3) @(posedge ref_clk);
      chk({24'h000000, outs}, {24'h000000, 3'b100, ~m[7:3]});
    end
    // threshold 6 counts, leave at 6 plus hysteresis
    for (int i = 0; i < 4; i++)
    begin
      cs <= CS_SEQ[i];
      repeat (3) @(posedge ref_clk);
      chk({24'h000000, outs}, {24'h000000, OUT_SEQ[i]});
      rd_reg(sense_trim_pkg::IDX_LIGHT_LOAD_STATUS, {31'h0, OUT_SEQ[i][7]});
    end
    cs <= 12'hfff;
    repeat (3) @(posedge ref_clk);
    chk({24'h000000, outs}, 32'h0000007f);
    rd_reg(sense_trim_pkg::IDX_LIGHT_LOAD_STATUS, 32'h00000000);
    // calibration as software does it: load channel first, then the rest
    raw2 <= 12'h960;
    raw3 <= 12'hb54;
    wr_reg(sense_trim_pkg::IDX_LOAD_TRIM, 32'h000000db);
    wr_reg(sense_trim_pkg::IDX_SECOND_TRIM, 32'h00000068);
    repeat (2) @(posedge ref_clk);
    rd_reg(sense_trim_pkg::IDX_LOAD_VALUE, {20'h0, sense_trim_pkg::CAL_TARGET_CODE});
    rd_reg(sense_trim_pkg::IDX_SECOND_VALUE, {20'h0, sense_trim_pkg::CAL_TARGET_CODE});
    chk({20'h0, val2}, {20'h0, sense_trim_pkg::CAL_TARGET_CODE});
    chk({20'h0, val3}, {20'h0, sense_trim_pkg::CAL_TARGET_CODE});
    report_and_stop();
  end
endmodule : sense_trim_light_load_ctrl_tb

`default_nettype wire
